// *** card_port_pkg.sv ***
package card_port_pkg;
	// interface modes, decoded from the ata_sel_n pin and io_configured
	typedef enum logic [1:0]
	{
		MODE_MEMORY = 2'h0,
		MODE_IO = 2'h1,
		MODE_IDE = 2'h2
	} card_mode_t;

	typedef enum logic [1:0]
	{
		RST_IDLE = 2'h0,
		RST_BUSY = 2'h1,
		RST_DONE = 2'h2
	} reset_state_t;

	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;
	// time the reset processing takes, in ns
	localparam int RESET_WORK_NS = 2000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int RESET_WORK_CYCLES = (RESET_WORK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CNT_W = 16;
	// cycles one pulse-mode interrupt holds the line low
	localparam int IRQ_PULSE_CYCLES = 4;
	localparam int PULSE_CNT_W = 4;
endpackage : card_port_pkg

// *** pin_sync_if.sv ***
interface pin_sync_if #(parameter int WIDTH = 10);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] fall;
	modport owner (output raw, input level, rise, fall);
	modport sync (input raw, output level, rise, fall);
endinterface : pin_sync_if

// *** pin_sync.sv ***
module pin_sync #(
	parameter int WIDTH = 10
) (
	input wire logic ref_clk,
	input wire logic rst,
	pin_sync_if.sync pins
);
	import card_port_pkg::*;

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_r;

	// a change counts only when stages two and three agree
	always_ff @(posedge ref_clk)
	begin
		s1_r <= pins.raw;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge ref_clk)
			begin
				if (rst)
					level_r[i] <= 1'b1;
				else if (s2_r[i] == s3_r[i])
					level_r[i] <= s3_r[i];
			end
			assign pins.rise[i] = (s2_r[i] == s3_r[i]) && s3_r[i] && !level_r[i];
			assign pins.fall[i] = (s2_r[i] == s3_r[i]) && !s3_r[i] && level_r[i];
		end
	endgenerate

	assign pins.level = level_r;
endmodule : pin_sync

// *** card_host_strobe_control.sv ***
module card_host_strobe_control #(
	parameter int RESET_CYCLES = card_port_pkg::RESET_WORK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic io_wr_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic attr_sel_n,
	input wire logic ata_sel_n,
	input wire logic dma_ack,
	input wire logic burst_stop,
	input wire logic card_reset,
	input wire logic io_configured,
	input wire logic irq_level_mode,
	input wire logic irq_event,
	input wire logic soft_reset,
	input wire logic dma_want,
	input wire logic udma_active,
	input wire logic core_busy,
	output card_port_pkg::card_mode_t mode,
	output logic io_write_latch,
	output logic cfg_write_latch,
	output logic read_drive_en,
	output logic attr_space,
	output logic burst_end,
	output logic ready,
	output logic irq_n,
	output logic intrq,
	output logic dma_req,
	output logic dev_reset
);
	import card_port_pkg::*;

	// ==============================
	// pin synchronisers
	// ==============================
	localparam int B_IOWR = 0;
	localparam int B_OE = 1;
	localparam int B_WE = 2;
	localparam int B_REG = 3;
	localparam int B_ATA = 4;
	localparam int B_ACK = 5;
	localparam int B_STOP = 6;
	localparam int B_RST = 7;
	localparam int NPINS = 8;

	pin_sync_if #(.WIDTH(NPINS)) pins ();
	assign pins.raw = {card_reset, burst_stop, dma_ack, ata_sel_n,
		attr_sel_n, we_n, oe_n, io_wr_n};

	pin_sync #(.WIDTH(NPINS)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pins(pins)
	);

	card_mode_t mode_nxt;
	always_comb
	begin
		if (!pins.level[B_ATA])
			mode_nxt = MODE_IDE;
		else if (io_configured)
			mode_nxt = MODE_IO;
		else
			mode_nxt = MODE_MEMORY;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			mode <= MODE_MEMORY;
		else
			mode <= mode_nxt;
	end

	// ==============================
	// reset sequencing
	// ==============================
	reset_state_t rst_state_r;
	logic [BUSY_CNT_W-1:0] busy_cnt_r;
	logic pin_reset;
	logic pin_seen_low_r;
	logic start_reset;

	// in memory and I/O mode pin reset only counts after the pin has been low once, so a pin
	// held high from power-up gives just the power-up reset
	always_comb
	begin
		if (mode == MODE_IDE)
			pin_reset = !pins.level[B_RST];
		else
			pin_reset = pins.level[B_RST] && pin_seen_low_r;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pin_seen_low_r <= 1'b0;
		else if (!pins.level[B_RST])
			pin_seen_low_r <= 1'b1;
	end

	assign start_reset = pin_reset || soft_reset;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rst_state_r <= RST_BUSY;
			busy_cnt_r <= '0;
		end
		else if (start_reset)
		begin
			rst_state_r <= RST_BUSY;
			busy_cnt_r <= '0;
		end
		else
		begin
			unique case (rst_state_r)
				RST_IDLE: rst_state_r <= RST_BUSY;
				RST_BUSY:
				begin
					if (busy_cnt_r == BUSY_CNT_W'(RESET_CYCLES - 1))
						rst_state_r <= RST_DONE;
					else
						busy_cnt_r <= busy_cnt_r + 1'b1;
				end
				RST_DONE: rst_state_r <= RST_DONE;
				default: rst_state_r <= RST_BUSY;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			dev_reset <= 1'b1;
		else
			dev_reset <= start_reset || (rst_state_r != RST_DONE);
	end

	// ==============================
	// ready and strobes
	// ==============================
	logic running;
	assign running = (rst_state_r == RST_DONE) && !start_reset;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ready <= 1'b0;
		else
			ready <= running && !core_busy;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			io_write_latch <= 1'b0;
			cfg_write_latch <= 1'b0;
			read_drive_en <= 1'b0;
			attr_space <= 1'b0;
		end
		else
		begin
			// rising edge of the write strobe ends the cycle: latch then
			io_write_latch <= running && (mode != MODE_MEMORY) && pins.rise[B_IOWR];
			cfg_write_latch <= running && (mode != MODE_IDE) && pins.rise[B_WE];
			attr_space <= !pins.level[B_REG];
			unique case (mode)
				MODE_MEMORY: read_drive_en <= running && !pins.level[B_OE];
				// oe only reaches attribute space (CIS, config) in I/O mode
				MODE_IO: read_drive_en <= running && !pins.level[B_OE]
					&& !pins.level[B_REG];
				default: read_drive_en <= 1'b0;
			endcase
		end
	end

	// ==============================
	// ultra DMA and DMA request
	// ==============================
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			burst_end <= 1'b0;
			dma_req <= 1'b0;
		end
		else
		begin
			burst_end <= udma_active && (mode == MODE_IDE) && pins.rise[B_STOP];
			dma_req <= running && (mode == MODE_IDE) && dma_want;
		end
	end

	// ==============================
	// interrupts
	// ==============================
	logic [PULSE_CNT_W-1:0] pulse_cnt_r;
	logic irq_pend;

	always_ff @(posedge ref_clk)
	begin
		if (rst || !running)
			pulse_cnt_r <= '0;
		else if (irq_event && !irq_level_mode)
			pulse_cnt_r <= PULSE_CNT_W'(IRQ_PULSE_CYCLES);
		else if (pulse_cnt_r != '0)
			pulse_cnt_r <= pulse_cnt_r - 1'b1;
	end

	assign irq_pend = irq_level_mode ? irq_event : (pulse_cnt_r != '0);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			irq_n <= 1'b1;
			intrq <= 1'b0;
		end
		else
		begin
			irq_n <= !(running && mode == MODE_IO && irq_pend);
			intrq <= running && mode == MODE_IDE && irq_event;
		end
	end

	// ==============================
	// checks
	// ==============================
	sequence s_iowr_rise;
		pins.rise[B_IOWR] && running && mode != MODE_MEMORY;
	endsequence

	AST_IOWR_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
		s_iowr_rise |=> io_write_latch)
		else $error("io write not latched");
	AST_IOWR_MEM: assert property (@(posedge ref_clk) disable iff (rst)
		mode == MODE_MEMORY |=> !io_write_latch)
		else $error("io write latched in memory mode");
	AST_STOP: assert property (@(posedge ref_clk) disable iff (rst)
		(udma_active && mode == MODE_IDE && pins.rise[B_STOP]) |=> burst_end)
		else $error("burst not ended on stop");
	AST_OE_IO: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == MODE_IO && pins.level[B_REG]) |=> !read_drive_en)
		else $error("io mode oe drove common data");
	AST_READY_BUSY: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(dev_reset) |-> !ready)
		else $error("ready high during reset");
	sequence s_irq_pulse_start;
		irq_event && !irq_level_mode && running && mode == MODE_IO && mode_nxt == MODE_IO;
	endsequence

	AST_IRQ_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
		s_irq_pulse_start ##1 (running && !irq_level_mode) |=> !irq_n)
		else $error("pulse interrupt missing");
	AST_INTRQ_IO: assert property (@(posedge ref_clk) disable iff (rst)
		mode != MODE_IDE |=> !intrq)
		else $error("intrq outside ide mode");
	AST_IDE_RESET: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == MODE_IDE && !pins.level[B_RST]) |=> dev_reset)
		else $error("ide reset ignored");
	AST_DMA_REQ: assert property (@(posedge ref_clk) disable iff (rst)
		mode != MODE_IDE |=> !dma_req)
		else $error("dma request outside ide mode");
endmodule : card_host_strobe_control

// *** host_model.sv ***
// ============================================================
// host side of the card port
module host_model
(
	input wire logic ref_clk,
	input wire logic ready,
	input wire logic dma_req,
	output logic io_wr_n,
	output logic oe_n,
	output logic we_n,
	output logic attr_sel_n,
	output logic ata_sel_n,
	output logic dma_ack,
	output logic burst_stop,
	output logic card_reset
);
	timeunit 1ns;
	timeprecision 100ps;
	// mask bits: io_wr_n oe_n we_n attr_sel_n ata_sel_n (ack) burst_stop card_reset
	logic [7:0] lines = 8'h1F;
	assign {card_reset, burst_stop} = lines[7:6];
	assign {ata_sel_n, attr_sel_n, we_n, oe_n, io_wr_n} = lines[4:0];
	// ack follows the request half a cycle late, on the falling edge, never combinationally
	always @(negedge ref_clk) dma_ack <= dma_req;
	task pulse(input logic [7:0] m);
		for (int i = 0; i < 300 && ready !== 1'b1; i++)
			@(negedge ref_clk);
		lines = lines ^ m;
		repeat (6) @(negedge ref_clk);
		lines = lines ^ m;
		repeat (8) @(negedge ref_clk);
	endtask : pulse
	task set(input int i, input logic v);
		lines[i] = v;
	endtask : set
endmodule : host_model

// *** card_host_strobe_control_bench.sv ***
// ============================================================
// bench
module card_host_strobe_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import card_port_pkg::*;
	localparam int RC = 4;
	logic ref_clk = 0, rst = 1, io_configured = 0, irq_level_mode = 0, irq_event = 0;
	logic soft_reset = 0, dma_want = 0, udma_active = 0, core_busy = 0;
	logic io_wr_n, oe_n, we_n, attr_sel_n, ata_sel_n, dma_ack, burst_stop, card_reset;
	card_mode_t mode;
	logic io_write_latch, cfg_write_latch, read_drive_en, attr_space, burst_end;
	logic ready, irq_n, intrq, dma_req, dev_reset;
	int n_fail = 0, checks_done = 0, cnt[7], n;
	logic [31:0] s = 54;
	host_model host_model_i (.ref_clk(ref_clk), .ready(ready), .dma_req(dma_req),
		.io_wr_n(io_wr_n), .oe_n(oe_n), .we_n(we_n), .attr_sel_n(attr_sel_n),
		.ata_sel_n(ata_sel_n), .dma_ack(dma_ack), .burst_stop(burst_stop),
		.card_reset(card_reset));
	card_host_strobe_control #(.RESET_CYCLES(RC)) card_host_strobe_control_i (
		.ref_clk(ref_clk), .rst(rst), .io_wr_n(io_wr_n), .oe_n(oe_n), .we_n(we_n),
		.attr_sel_n(attr_sel_n), .ata_sel_n(ata_sel_n), .dma_ack(dma_ack),
		.burst_stop(burst_stop), .card_reset(card_reset), .io_configured(io_configured),
		.irq_level_mode(irq_level_mode),
		.irq_event(irq_event), .soft_reset(soft_reset), .dma_want(dma_want),
		.udma_active(udma_active), .core_busy(core_busy), .mode(mode),
		.io_write_latch(io_write_latch), .cfg_write_latch(cfg_write_latch),
		.read_drive_en(read_drive_en),
		.attr_space(attr_space), .burst_end(burst_end), .ready(ready), .irq_n(irq_n),
		.intrq(intrq), .dma_req(dma_req), .dev_reset(dev_reset));
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cnt[0] += (io_write_latch === 1'b1);
		cnt[1] += (read_drive_en === 1'b1);
		cnt[2] += (burst_end === 1'b1);
		cnt[3] += (irq_n === 1'b0);
		cnt[4] += (cfg_write_latch === 1'b1);
		cnt[5] += (dev_reset === 1'b1);
		cnt[6] += (attr_space === 1'b1);
	end
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : rnd
	// oe held low: memory mode always reads, io mode only attribute space
	function automatic logic exp_drive(input card_mode_t m, input logic reg_low);
		return (m == MODE_MEMORY) || (m == MODE_IO && reg_low);
	endfunction : exp_drive
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task close_out();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task tick(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : tick
	task clr();
		foreach (cnt[i]) cnt[i] = 0;
	endtask : clr
	task wait_ready();
		for (int i = 0; i < 300 && ready !== 1'b1; i++)
			tick(1);
		chk("ready", ready, 1);
	endtask : wait_ready
	task do_rst();
		rst = 1;
		tick(6);
		rst = 0;
		tick(RC - 1);
		chk("ready_busy", ready, 0);
		wait_ready();
	endtask : do_rst
	initial
	begin
		// the tests need well under two thousand cycles
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		close_out();
	end
	initial
	begin
		do_rst();
		// ============================================================
		// memory mode
		chk("mode", mode, MODE_MEMORY);
		clr();
		host_model_i.pulse(8'h01);
		chk("wr_ignored", cnt[0], 0);
		host_model_i.pulse(8'h02);
		chk("oe_read", cnt[1] != 0, exp_drive(MODE_MEMORY, 1'b0));
		host_model_i.pulse(8'h0C);
		chk("attr", cnt[6] != 0, 1);
		chk("cfg_write", cnt[4], 1);
		core_busy = 1;
		tick(3);
		chk("busy", ready, 0);
		core_busy = 0;
		tick(3);
		chk("idle", ready, 1);
		host_model_i.pulse(8'h80);
		chk("pin_reset", cnt[5] != 0, 1);
		wait_ready();
		$display("memory test done");
		// ============================================================
		// io mode; random burst of writes
		io_configured = 1;
		tick(6);
		chk("mode", mode, MODE_IO);
		clr();
		n = rnd() % 3 + 1;
		repeat (n) host_model_i.pulse(8'h09);
		chk("wr_count", cnt[0], n);
		host_model_i.pulse(8'h02);
		chk("oe_refused", cnt[1] != 0, exp_drive(MODE_IO, 1'b0));
		host_model_i.pulse(8'h0A);
		chk("oe_cfg", cnt[1] != 0, exp_drive(MODE_IO, 1'b1));
		irq_event = 1;
		tick(1);
		irq_event = 0;
		tick(12);
		chk("irq_pulse", cnt[3], IRQ_PULSE_CYCLES);
		irq_level_mode = 1;
		irq_event = 1;
		tick(6);
		chk("irq_level", irq_n, 0);
		irq_event = 0;
		soft_reset = 1;
		tick(1);
		soft_reset = 0;
		tick(6);
		chk("soft_reset", cnt[5] != 0, 1);
		wait_ready();
		$display("io test done");
		// ============================================================
		// mid-run reset with the reset pin held high, then ide mode
		io_configured = 0;
		host_model_i.set(7, 1);
		do_rst();
		tick(12);
		chk("reset_once", ready, 1);
		host_model_i.set(4, 0);
		tick(6);
		chk("mode", mode, MODE_IDE);
		irq_event = 1;
		tick(6);
		chk("intrq", intrq, 1);
		irq_event = 0;
		dma_want = 1;
		tick(6);
		chk("dma_req", dma_req, 1);
		udma_active = 1;
		clr();
		host_model_i.pulse(8'h40);
		chk("burst_end", cnt[2], 1);
		host_model_i.pulse(8'h02);
		chk("oe_ide", cnt[1] != 0, exp_drive(MODE_IDE, 1'b0));
		host_model_i.pulse(8'h80);
		chk("ide_reset", cnt[5] != 0, 1);
		$display("ide test done");
		close_out();
	end
endmodule : card_host_strobe_control_bench
